// *** clock_select_pkg.sv ***
package clock_select_pkg;

  // Widths
  localparam int unsigned MODE_W = 4;
  localparam int unsigned FREQ_W = 3;
  localparam int unsigned TUNE_W = 5;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  // Clock mode configuration encodings
  localparam logic [3:0] CFG_LOW_POWER = 4'h0;
  localparam logic [3:0] CFG_STANDARD = 4'h1;
  localparam logic [3:0] CFG_HIGH_SPEED = 4'h2;
  localparam logic [3:0] CFG_RC_CLKOUT = 4'h3;
  localparam logic [3:0] CFG_EXT_CLKOUT = 4'h4;
  localparam logic [3:0] CFG_EXT_GPIO = 4'h5;
  localparam logic [3:0] CFG_HS_MULT = 4'h6;
  localparam logic [3:0] CFG_RC_GPIO = 4'h7;
  localparam logic [3:0] CFG_INT_DUAL_GPIO = 4'h8;
  localparam logic [3:0] CFG_INT_CLKOUT = 4'h9;

  // Internal frequency select codes
  localparam logic [2:0] FREQ_LOW = 3'h0;
  localparam logic [2:0] FREQ_HALF = 3'h6;
  localparam logic [2:0] FREQ_FULL = 3'h7;

  // Register offsets
  localparam logic [1:0] ADDR_CLOCK_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_OSC_TUNING = 2'h1;
  localparam logic [1:0] ADDR_PORTA_LATCH = 2'h2;
  localparam logic [1:0] ADDR_PORTA_DIR = 2'h3;

  // Field positions
  localparam int unsigned FREQ_LSB = 4;
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned LF_SEL_BIT = 7;
  localparam int unsigned MULT_EN_BIT = 6;
  localparam int unsigned TUNE_LSB = 0;
  localparam int unsigned BIT_SIX = 6;
  localparam int unsigned BIT_SEVEN = 7;

  // Reset values
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic [4:0] TUNE_RESET = 5'h00;
  localparam logic [1:0] LATCH_RESET = 2'h0;
  localparam logic [1:0] DIR_RESET = 2'h3;

  // Divider widths: divide by 4 and by 256
  localparam int unsigned CLKOUT_DIV_W = 2;
  localparam int unsigned LF_DIV_W = 8;

  // Decoded primary modes
  typedef enum {
    low_power_crystal_mode,
    standard_crystal_mode,
    high_speed_crystal_mode,
    high_speed_multiplied_mode,
    ext_resistor_cap_clkout,
    ext_resistor_cap_gpio,
    internal_osc_clkout_mode,
    internal_osc_dual_gpio,
    external_clock_clkout,
    external_clock_gpio
  } osc_mode_t;

  // Internal clock source choice
  typedef enum logic [1:0] {
    src_fast_direct,
    src_slow_direct,
    src_postscaled,
    src_fast_div256
  } clk_source_t;

endpackage : clock_select_pkg

// *** clock_divider.sv ***
`timescale 1ns/1ps
// Power-of-two divider that counts only while run is high, square output
module clock_divider
  import clock_select_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  output logic div_out
);

  // Division counter
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  // Registered output keeps the pin free of glitches
  logic next_div_out;

  // Next count and output level
  always_comb begin
    next_count = count;
    next_div_out = div_out;
    if (!rst_n || !run) begin
      // Held at zero so the phase restarts cleanly
      next_count = '0;
      next_div_out = 1'b0;
    end else begin
      next_count = count + 1'b1;
      next_div_out = next_count[WIDTH-1];
    end
  end

  // Register stage
  always_ff @(posedge clock) begin
    count <= next_count;
    div_out <= next_div_out;
  end

endmodule : clock_divider

// *** oscillator_mode_clock_select.sv ***
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Ten primary modes from four-bit field
// RQ2: External clock modes need no start-up delay
// RQ3: External clock clkout drives clock divided by four
// RQ4: External clock gpio frees output as bit six
// RQ5: RC clkout drives oscillator divided by four
// RQ6: RC gpio frees output as bit six
// RQ7: Multiplied mode runs crystal times four
// RQ8: Multiplied mode hides software multiplier enable
// RQ9: Crystal multiplier only with field 0110
// RQ10: Software multiplier on fast internal oscillator
// RQ11: Multiplier needs internal mode, frequency 111/110
// RQ12: Fast oscillator direct or through postscaler
// RQ13: Fast oscillator on for 125k-8M, or selected 31k
// RQ14: Low-frequency select picks div256 or slow oscillator
// RQ15: Slow oscillator on when selected or feature needs
// RQ16: Frequency select picks fast, slow, postscaled
// RQ17: Internal clkout: output divided, input bit seven
// RQ18: Internal dual gpio: both pins port bits
// RQ19: High-speed mode may take an external clock
// RQ20: Resonators above 3.5 MHz use high-speed mode
// RQ21: Mode field captured at reset, decoded statically
module oscillator_mode_clock_select
  import clock_select_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [MODE_W-1:0] clock_mode_cfg,
  input wire logic power_up_timer_en,
  input wire logic fail_safe_monitor_en,
  input wire logic watchdog_en,
  input wire logic two_speed_start_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic osc_input_pin_in,
  output logic osc_input_pin_out,
  output logic osc_input_pin_oe,
  input wire logic osc_output_pin_in,
  output logic osc_output_pin_out,
  output logic osc_output_pin_oe,
  output osc_mode_t active_mode,
  output clk_source_t active_source,
  output logic crystal_amp_en,
  output logic startup_delay_needed,
  output logic multiplier_active,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic derived_low_clock
);

  // Static configuration, captured while reset is low
  logic [MODE_W-1:0] mode_cfg;
  logic [MODE_W-1:0] next_mode_cfg;

  // Software registers
  logic [FREQ_W-1:0] internal_freq_select;
  logic [FREQ_W-1:0] next_internal_freq_select;
  logic low_freq_source_sel;
  logic next_low_freq_source_sel;
  logic multiplier_sw_enable;
  logic next_multiplier_sw_enable;
  logic [TUNE_W-1:0] tune;
  logic [TUNE_W-1:0] next_tune;
  logic [1:0] porta_latch;
  logic [1:0] next_porta_latch;
  logic [1:0] porta_dir;
  logic [1:0] next_porta_dir;
  logic [DATA_W-1:0] next_reg_rdata;

  // Pin synchronisers, two stages each
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;

  // Mode decode results
  osc_mode_t mode;
  logic internal_primary;
  logic ext_clock_mode;
  logic crystal_mode;
  logic clkout_mode;
  logic out_gpio_mode;
  logic mult_allowed;
  logic clkout_level;

  // Pins from outside are sampled twice before any use
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= {osc_input_pin_in, osc_output_pin_in};
      pin_sync <= pin_meta;
    end
  end

  // Configuration capture
  always_comb begin
    // RQ21: sampled at reset
    next_mode_cfg = rst_n ? mode_cfg : clock_mode_cfg;
  end

  always_ff @(posedge clock) begin
    mode_cfg <= next_mode_cfg;
  end

  // Field decode into one of ten modes
  always_comb begin
    // RQ1: ten mode decode
    case (mode_cfg)
      CFG_LOW_POWER: mode = low_power_crystal_mode;
      CFG_STANDARD: mode = standard_crystal_mode;
      CFG_HIGH_SPEED: mode = high_speed_crystal_mode;
      CFG_HS_MULT: mode = high_speed_multiplied_mode;
      CFG_RC_CLKOUT: mode = ext_resistor_cap_clkout;
      CFG_RC_GPIO: mode = ext_resistor_cap_gpio;
      CFG_INT_CLKOUT: mode = internal_osc_clkout_mode;
      CFG_INT_DUAL_GPIO: mode = internal_osc_dual_gpio;
      CFG_EXT_CLKOUT: mode = external_clock_clkout;
      CFG_EXT_GPIO: mode = external_clock_gpio;
      // Unused codes fall back to the RC clkout mode
      default: mode = ext_resistor_cap_clkout;
    endcase
  end

  // Mode class flags
  always_comb begin
    internal_primary = (mode == internal_osc_clkout_mode) || (mode == internal_osc_dual_gpio);
    ext_clock_mode = (mode == external_clock_clkout) || (mode == external_clock_gpio);
    // RQ19: high-speed amplifier may be overdriven
    crystal_mode = (mode == low_power_crystal_mode) || (mode == standard_crystal_mode) ||
                   (mode == high_speed_crystal_mode) || (mode == high_speed_multiplied_mode);
    // RQ3: external clock clkout
    // RQ5: RC clkout
    clkout_mode = (mode == external_clock_clkout) || (mode == ext_resistor_cap_clkout) ||
                  (mode == internal_osc_clkout_mode);
    // RQ4: external clock frees bit six
    // RQ6: RC frees bit six
    out_gpio_mode = (mode == external_clock_gpio) || (mode == ext_resistor_cap_gpio) ||
                    (mode == internal_osc_dual_gpio);
  end

  // Multiplier availability for the internal oscillator
  always_comb begin
    // RQ11: mode and frequency gate
    // RQ8: never in multiplied crystal mode
    mult_allowed = internal_primary &&
                   ((internal_freq_select == FREQ_FULL) || (internal_freq_select == FREQ_HALF));
  end

  // Register write decode and next values
  always_comb begin
    next_internal_freq_select = internal_freq_select;
    next_low_freq_source_sel = low_freq_source_sel;
    next_multiplier_sw_enable = multiplier_sw_enable;
    next_tune = tune;
    next_porta_latch = porta_latch;
    next_porta_dir = porta_dir;
    if (!rst_n) begin
      // Defined state after reset
      next_internal_freq_select = FREQ_RESET;
      next_low_freq_source_sel = 1'b0;
      next_multiplier_sw_enable = 1'b0;
      next_tune = TUNE_RESET;
      next_porta_latch = LATCH_RESET;
      next_porta_dir = DIR_RESET;
    end else begin
      if (reg_write) begin
        case (reg_addr)
          ADDR_CLOCK_CONTROL: begin
            next_internal_freq_select = reg_wdata[FREQ_LSB +: FREQ_W];
          end
          ADDR_OSC_TUNING: begin
            next_low_freq_source_sel = reg_wdata[LF_SEL_BIT];
            next_multiplier_sw_enable = reg_wdata[MULT_EN_BIT];
            next_tune = reg_wdata[TUNE_LSB +: TUNE_W];
          end
          ADDR_PORTA_LATCH: begin
            next_porta_latch = {reg_wdata[BIT_SEVEN], reg_wdata[BIT_SIX]};
          end
          ADDR_PORTA_DIR: begin
            next_porta_dir = {reg_wdata[BIT_SEVEN], reg_wdata[BIT_SIX]};
          end
          default: begin
            // Unmapped offsets take no write
          end
        endcase
      end
      // RQ11: bit held clear when unavailable
      // Checked after the write so a write in a barred state is dropped,
      // and a later frequency change also drops a bit that was set
      if (!mult_allowed) begin
        next_multiplier_sw_enable = 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    next_reg_rdata = '0;
    if (rst_n && reg_read) begin
      case (reg_addr)
        ADDR_CLOCK_CONTROL: begin
          next_reg_rdata[FREQ_LSB +: FREQ_W] = internal_freq_select;
          // Active source shows the block's own choice
          next_reg_rdata[SRC_LSB +: 2] = active_source;
        end
        ADDR_OSC_TUNING: begin
          next_reg_rdata[LF_SEL_BIT] = low_freq_source_sel;
          // RQ8: reads zero when unavailable
          next_reg_rdata[MULT_EN_BIT] = multiplier_sw_enable;
          next_reg_rdata[TUNE_LSB +: TUNE_W] = tune;
        end
        ADDR_PORTA_LATCH: begin
          // Port bits read the synchronised pin levels
          next_reg_rdata[BIT_SEVEN] = pin_sync[1];
          next_reg_rdata[BIT_SIX] = pin_sync[0];
        end
        ADDR_PORTA_DIR: begin
          next_reg_rdata[BIT_SEVEN] = porta_dir[1];
          next_reg_rdata[BIT_SIX] = porta_dir[0];
        end
        default: begin
          // Unmapped offsets read zero
          next_reg_rdata = '0;
        end
      endcase
    end
  end

  // Register stage for software state and read data
  always_ff @(posedge clock) begin
    internal_freq_select <= next_internal_freq_select;
    low_freq_source_sel <= next_low_freq_source_sel;
    multiplier_sw_enable <= next_multiplier_sw_enable;
    tune <= next_tune;
    porta_latch <= next_porta_latch;
    porta_dir <= next_porta_dir;
    reg_rdata <= next_reg_rdata;
  end

  // Internal clock source choice
  always_comb begin
    // RQ16: source from frequency select
    // RQ12: direct or postscaled fast clock
    case (internal_freq_select)
      FREQ_FULL: active_source = src_fast_direct;
      // RQ14: low-frequency source select
      FREQ_LOW: active_source = low_freq_source_sel ? src_fast_div256 : src_slow_direct;
      default: active_source = src_postscaled;
    endcase
  end

  // Oscillator enables and multiplier
  always_comb begin
    active_mode = mode;
    // RQ13: fast oscillator enable
    fast_osc_en = internal_primary && (active_source != src_slow_direct);
    // RQ15: slow oscillator enable
    slow_osc_en = (internal_primary && (active_source == src_slow_direct)) ||
                  power_up_timer_en || fail_safe_monitor_en || watchdog_en || two_speed_start_en;
    // RQ7: crystal times four
    // RQ9: only with field 0110
    // RQ10: software enabled internal path
    multiplier_active = (mode_cfg == CFG_HS_MULT) || (multiplier_sw_enable && mult_allowed);
    crystal_amp_en = crystal_mode;
    // RQ2: no start-up delay for external clock
    startup_delay_needed = crystal_mode && !ext_clock_mode;
  end

  // Divide-by-four clock output; device clock stands for the oscillator
  clock_divider #(
    .WIDTH(CLKOUT_DIV_W)
  ) clkout_divider (
    .clock(clock),
    .rst_n(rst_n),
    .run(clkout_mode),
    .div_out(clkout_level)
  );

  // Divide-by-256 path for the derived low clock
  clock_divider #(
    .WIDTH(LF_DIV_W)
  ) low_clock_divider (
    .clock(clock),
    .rst_n(rst_n),
    // RQ14: divider runs only when chosen
    .run(internal_primary && (active_source == src_fast_div256)),
    .div_out(derived_low_clock)
  );

  // Pin function muxing
  always_comb begin
    // Crystal modes leave both pins undriven, as do the three gpio modes while both port bits are set as inputs
    osc_input_pin_out = 1'b0;
    osc_input_pin_oe = 1'b0;
    osc_output_pin_out = 1'b0;
    osc_output_pin_oe = 1'b0;
    // RQ17: input pin is bit seven
    // RQ18: both pins are port bits
    if (internal_primary) begin
      osc_input_pin_out = porta_latch[1];
      osc_input_pin_oe = !porta_dir[1];
    end
    if (clkout_mode) begin
      // RQ17: divided clock on output pin
      osc_output_pin_out = clkout_level;
      osc_output_pin_oe = 1'b1;
    end else if (out_gpio_mode) begin
      // Direction bit high means input, as on the port
      osc_output_pin_out = porta_latch[0];
      osc_output_pin_oe = !porta_dir[0];
    end
  end

endmodule : oscillator_mode_clock_select

// *** osc_select_checker_assertions.sv ***
`timescale 1ns/1ps
// Port-level checks for the clock select block
module osc_select_checker
  import clock_select_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic power_up_timer_en,
  input wire logic fail_safe_monitor_en,
  input wire logic watchdog_en,
  input wire logic two_speed_start_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic osc_input_pin_oe,
  input wire logic osc_output_pin_out,
  input wire logic osc_output_pin_oe,
  // Mode type rides on a 2-state base, so it comes in as a variable, not a net
  input var osc_mode_t active_mode,
  input wire clk_source_t active_source,
  input wire logic startup_delay_needed,
  input wire logic multiplier_active,
  input wire logic fast_osc_en,
  input wire logic slow_osc_en
);
  // One domain, reset masks everything
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Only clock-out modes: a port bit on the same pin may rise and stay high
  a_clkout_wave: assert property (active_mode inside {external_clock_clkout, ext_resistor_cap_clkout,
    internal_osc_clkout_mode} && $rose(osc_output_pin_out) && osc_output_pin_oe |->
    ##1 osc_output_pin_out ##1 !osc_output_pin_out ##1 !osc_output_pin_out ##1 osc_output_pin_out)
    else $error("divided clock output lost its 2 high 2 low shape");
  a_clkout_drive: assert property (active_mode inside {external_clock_clkout, ext_resistor_cap_clkout,
    internal_osc_clkout_mode} |-> osc_output_pin_oe)
    else $error("clock output pin not driven in a clock-out mode");
  a_no_startup: assert property (active_mode inside {external_clock_clkout, external_clock_gpio}
    |-> !startup_delay_needed)
    else $error("start-up delay asked in an external clock mode");
  a_hs_multiplied: assert property (active_mode == high_speed_multiplied_mode |-> multiplier_active)
    else $error("multiplier idle in multiplied crystal mode");
  a_mult_gated: assert property (multiplier_active |-> active_mode == high_speed_multiplied_mode ||
    (active_mode inside {internal_osc_clkout_mode, internal_osc_dual_gpio} &&
    active_source inside {src_fast_direct, src_postscaled}))
    else $error("multiplier running outside its allowed modes");
  a_mult_refused: assert property (reg_write && reg_addr == ADDR_OSC_TUNING && !(active_mode inside
    {internal_osc_clkout_mode, internal_osc_dual_gpio, high_speed_multiplied_mode}) |=> !multiplier_active)
    else $error("software enable took effect where it is unavailable");
  a_slow_forced: assert property (power_up_timer_en || fail_safe_monitor_en || watchdog_en ||
    two_speed_start_en |-> slow_osc_en)
    else $error("slow oscillator off while a feature needs it");
  a_fast_on: assert property (active_mode inside {internal_osc_clkout_mode, internal_osc_dual_gpio} &&
    active_source != src_slow_direct |-> fast_osc_en)
    else $error("fast oscillator off while selected");
  a_dual_gpio_dir: assert property (active_mode == internal_osc_dual_gpio && reg_write &&
    reg_addr == ADDR_PORTA_DIR |=> osc_output_pin_oe == !$past(reg_wdata[6]) &&
    osc_input_pin_oe == !$past(reg_wdata[7]))
    else $error("port pin direction does not follow its register");
  a_mode_static: assert property (rst_n |=> $stable(active_mode))
    else $error("mode changed outside reset");
endmodule : osc_select_checker

bind oscillator_mode_clock_select osc_select_checker checker_i (.clock, .rst_n, .power_up_timer_en,
  .fail_safe_monitor_en, .watchdog_en, .two_speed_start_en, .reg_addr, .reg_wdata, .reg_write,
  .osc_input_pin_oe, .osc_output_pin_out, .osc_output_pin_oe, .active_mode, .active_source,
  .startup_delay_needed, .multiplier_active, .fast_osc_en, .slow_osc_en);

// *** osc_partner.sv ***
`timescale 1ns/1ps
// Far side: an external clock source on the input pin, its inverse on the output pin
module osc_partner (
  input wire logic in_out,
  input wire logic in_oe,
  input wire logic out_out,
  input wire logic out_oe,
  output logic in_pin,
  output logic out_pin
);
  logic ext_clk = 1'b0; // Free running, unrelated in phase to the system clock
  // fast source fed in on the input pin
  initial forever #13 ext_clk = ~ext_clk;
  // Released pins keep changing, so a stale level never passes
  assign in_pin = in_oe ? in_out : ext_clk;
  assign out_pin = out_oe ? out_out : ~ext_clk;
endmodule : osc_partner

// *** oscillator_mode_clock_select_tb_top.sv ***
`timescale 1ns/1ps
module oscillator_mode_clock_select_tb_top;
  import clock_select_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] cfg = 4'h0;
  logic [3:0] feat = 4'h0; // Power-up, fail-safe, watchdog, two-speed
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic in_pin, in_out, in_oe, out_pin, out_out, out_oe;
  osc_mode_t active_mode;
  clk_source_t active_source;
  logic amp_en, startup, mult, fast_en, slow_en, low_clk;
  int n_fail = 0;
  int comparisons = 0;
  int seed = 88;
  // Expected decode, indexed by the mode field
  int emap [16] = '{0, 1, 2, 4, 8, 9, 3, 5, 7, 6, 4, 4, 4, 4, 4, 4};
  int m, src, cnt;
  logic [7:0] d, l;

  oscillator_mode_clock_select uut (.clock(clock), .rst_n(rst_n), .clock_mode_cfg(cfg),
    .power_up_timer_en(feat[0]), .fail_safe_monitor_en(feat[1]), .watchdog_en(feat[2]),
    .two_speed_start_en(feat[3]), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .osc_input_pin_in(in_pin), .osc_input_pin_out(in_out),
    .osc_input_pin_oe(in_oe), .osc_output_pin_in(out_pin), .osc_output_pin_out(out_out),
    .osc_output_pin_oe(out_oe), .active_mode(active_mode), .active_source(active_source),
    .crystal_amp_en(amp_en), .startup_delay_needed(startup), .multiplier_active(mult),
    .fast_osc_en(fast_en), .slow_osc_en(slow_en), .derived_low_clock(low_clk));
  osc_partner far (.in_out(in_out), .in_oe(in_oe), .out_out(out_out), .out_oe(out_oe),
    .in_pin(in_pin), .out_pin(out_pin));

  // 40 ns system clock
  initial forever #20 clock = ~clock;

  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // Rising edges seen on a divided clock over n cycles
  task automatic rises(input bit sel, input int n, output int c);
    logic p, v;
    c = 0;
    p = sel ? low_clk : out_out;
    repeat (n) begin
      @(posedge clock);
      #1;
      v = sel ? low_clk : out_out;
      if (v === 1'b1 && p === 1'b0) c++;
      p = v;
    end
  endtask : rises

  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end

  // Every mode code, each after its own reset
  initial begin
    for (int c = 0; c < 16; c++) begin
      // Reset and mode change launched on a rising edge
      @(posedge clock);
      cfg <= c[3:0];
      rst_n <= 1'b0;
      repeat (c == 0 ? 15 : 4) @(posedge clock);
      rst_n <= 1'b1;
      m = emap[c];
      #1;
      chk(active_mode === osc_mode_t'(m), "mode decode");
      chk(startup === (m < 4) && amp_en === (m < 4), "start-up delay");
      chk(mult === (m == 3), "crystal multiplier");
      // Divided clock on the output pin
      if (m inside {4, 6, 8}) begin
        rises(0, 16, cnt);
        chk(cnt == 4 && out_oe === 1'b1, "divided clock out");
      end
      if (m < 4) chk(out_oe === 1'b0 && in_oe === 1'b0, "crystal pins");
      // Pins freed as port bits
      if (m inside {5, 6, 7, 9}) begin
        l = 8'($random(seed));
        // Both port bits start as inputs, so no port pin is driven yet
        rd(ADDR_PORTA_DIR, d);
        chk(d === {DIR_RESET, 6'h00} && in_oe === 1'b0 && (m == 6 || out_oe === 1'b0), "direction reset");
        wr(ADDR_PORTA_DIR, 8'h00);
        wr(ADDR_PORTA_LATCH, l);
        #1;
        if (m != 6) chk(out_out === l[6] && out_oe === 1'b1, "port bit six");
        if (m inside {6, 7}) chk(in_out === l[7] && in_oe === 1'b1, "port bit seven");
        repeat (3) @(posedge clock);
        rd(ADDR_PORTA_LATCH, d);
        if (m != 6) chk(d[6] === l[6], "bit six read");
        if (m inside {6, 7}) chk(d[7] === l[7], "bit seven read");
        rd(ADDR_PORTA_DIR, d);
        chk(d === 8'h00, "direction read");
      end
      // Software multiplier, only in internal modes
      @(posedge clock);
      feat <= 4'($random(seed));
      wr(ADDR_OSC_TUNING, 8'h40);
      rd(ADDR_OSC_TUNING, d);
      chk(d === ((m inside {6, 7}) ? 8'h40 : 8'h00), "enable bit");
      chk(mult === (m inside {3, 6, 7}), "multiplier on");
      chk(slow_en === (|feat), "slow forced");
      if (m inside {6, 7}) begin
        wr(ADDR_CLOCK_CONTROL, 8'h00);
        rd(ADDR_OSC_TUNING, d);
        chk(d === 8'h00 && mult === 1'b0, "enable dropped");
        wr(ADDR_OSC_TUNING, 8'hff);
        rd(ADDR_OSC_TUNING, d);
        chk(d === 8'h9f, "tuning read");
        // All frequency codes with both low-frequency sources
        for (int f = 0; f < 16; f++) begin
          @(posedge clock);
          feat <= 4'($random(seed));
          wr(ADDR_OSC_TUNING, {f[3], 7'h00});
          wr(ADDR_CLOCK_CONTROL, {1'b0, f[2:0], 4'h0});
          src = f[2:0] == 3'h7 ? 0 : f[2:0] == 3'h0 ? (f[3] ? 3 : 1) : 2;
          rd(ADDR_CLOCK_CONTROL, d);
          chk(d[6:4] === f[2:0] && d[1:0] === src[1:0], "frequency read");
          chk(active_source === clk_source_t'(src), "source select");
          chk(fast_en === (src != 1) && slow_en === (src == 1 || |feat), "osc enables");
        end
        // Fast source divided by 256
        wr(ADDR_CLOCK_CONTROL, 8'h00);
        rises(1, 512, cnt);
        chk(cnt == 2, "low clock period");
      end
    end
    tally_and_finish();
  end
endmodule : oscillator_mode_clock_select_tb_top
